/* File: core/pio_pkg.sv */
package pio_pkg;

	// Line and port arrangement
	localparam int NUM_LINES = 48;
	localparam int NUM_GROUPS = 2;
	localparam int GROUP_W = 24;
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 6;
	localparam int EXT_BIT = 19;

	// APB address: register index times four
	localparam int ADDR_W = 8;
	localparam logic [3:0] IDX_GROUP0_A = 4'h0;
	localparam logic [3:0] IDX_GROUP1_A = 4'h4;
	localparam logic [3:0] IDX_COS_ENABLE = 4'h8;
	localparam logic [3:0] IDX_IRQ_STATUS = 4'h9;
	localparam logic [3:0] IDX_BUFFER_CTRL = 4'ha;
	localparam logic [1:0] SUB_CTRL = 2'h3;

	// Direction control field: a set bit makes the lines inputs
	localparam int DIR_A = 0;
	localparam int DIR_B = 1;
	localparam int DIR_C_LOW = 2;
	localparam int DIR_C_HIGH = 3;
	localparam int DIR_W = 4;

	// Values after reset
	localparam logic [DIR_W-1:0] DIR_RESET = 4'hf;
	localparam logic [NUM_LINES-1:0] LATCH_RESET = 48'h0;
	localparam logic [NUM_PORTS-1:0] COS_EN_RESET = 6'h00;
	localparam logic BUF_SOFT_RESET = 1'b0;
	localparam logic [NUM_LINES-1:0] PIN_RESET = 48'hffff_ffff_ffff; // Pull-up level of idle pins

	// Sticky interrupt sources, read and cleared at the status index
	typedef struct packed
	{
		logic ext1;
		logic ext0;
		logic cos;
	} pio_irq_type;

	localparam pio_irq_type IRQ_RESET = 3'h0;

endpackage

/* File: core/pio_top.sv */
// How it works
// [RULE_01] 48 lines in two groups, each of three 8-bit ports.
// [RULE_02] Port C of each group splits into two nibbles with own direction.
// [RULE_03] Each port is an input or a latched output holding the last write.
// [RULE_04] Any change on a monitored input sets a latched interrupt request.
// [RULE_05] Six enable bits gate change detection, one per 8-line port.
// [RULE_06] The change interrupt stays set until a software write clears it.
// [RULE_07] Rising edge of the external interrupt bit raises a group interrupt if jumpered.
// [RULE_08] Both external requests and the change request are ORed to one irq.
// [RULE_09] Line drivers follow the direction programmed for each port.
// [RULE_10] Software can disable the line drivers, leaving every line undriven.
// [RULE_11] Sixteen consecutive register locations decoded; base set by the system.
// [RULE_12] After reset no line is driven until software programs outputs.
// [RULE_13] Always-on jumper forces drivers on; soft jumper hands it to a register.
// [RULE_14] Indicator lights whenever an interrupt is pending, until software clears it.
// [RULE_15] Inputs are synchronised and compared with their last sample each cycle.
//
// Our own choices: the placing of the registers and register access over APB.
module pio_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pio_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [pio_pkg::NUM_LINES-1:0] line_in,
	output logic [pio_pkg::NUM_LINES-1:0] line_out,
	output logic [pio_pkg::NUM_LINES-1:0] line_oe,
	input wire logic [pio_pkg::NUM_GROUPS-1:0] external_irq_jumper,
	input wire logic buffer_always_on_jumper,
	input wire logic buffer_soft_control_jumper,
	output logic irq,
	output logic irq_led
);

	////////////////////////////////////////////////////////////////////////////
	// Direction field of one group widened to a per-line input mask
	function automatic logic [pio_pkg::GROUP_W-1:0] group_in_mask
	(
		input logic [pio_pkg::DIR_W-1:0] dir
	);
		group_in_mask = {{4{dir[pio_pkg::DIR_C_HIGH]}}, {4{dir[pio_pkg::DIR_C_LOW]}}, // [RULE_02]
			{8{dir[pio_pkg::DIR_B]}}, {8{dir[pio_pkg::DIR_A]}}}; // [RULE_03]
	endfunction

	// First line of the port that a data index selects; a group spans 24 lines,
	// so the group bit cannot simply be glued above the port number
	function automatic logic [5:0] port_base
	(
		input logic [3:0] index
	);
		port_base = (index[2] ? 6'(pio_pkg::GROUP_W) : 6'h0) + {1'b0, index[1:0], 3'h0}; // [RULE_01]
	endfunction

	logic [pio_pkg::NUM_LINES-1:0] latch;
	logic [pio_pkg::NUM_LINES-1:0] next_latch;
	logic [pio_pkg::DIR_W-1:0] dir [pio_pkg::NUM_GROUPS];
	logic [pio_pkg::DIR_W-1:0] next_dir [pio_pkg::NUM_GROUPS];
	logic [pio_pkg::NUM_PORTS-1:0] cos_en;
	logic [pio_pkg::NUM_PORTS-1:0] next_cos_en;
	logic buf_soft;
	logic next_buf_soft;
	pio_pkg::pio_irq_type status;
	pio_pkg::pio_irq_type next_status;
	pio_pkg::pio_irq_type set_ev;
	logic [pio_pkg::NUM_LINES-1:0] sync1;
	logic [pio_pkg::NUM_LINES-1:0] sync2;
	logic [pio_pkg::NUM_LINES-1:0] prev;
	logic [pio_pkg::NUM_LINES-1:0] in_mask;
	logic [pio_pkg::NUM_LINES-1:0] mon_mask;
	logic [pio_pkg::NUM_LINES-1:0] next_line_out;
	logic [pio_pkg::NUM_LINES-1:0] next_line_oe;
	logic [pio_pkg::NUM_LINES-1:0] rd_lines;
	logic [pio_pkg::NUM_GROUPS-1:0] ext_rise;
	logic buf_on;
	logic next_irq;
	logic next_prdata_valid;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [3:0] idx;
	logic addr_ok;
	logic wr;

	////////////////////////////////////////////////////////////////////////////
	// Per-group masks, external interrupt bit edge and monitored lines
	// Line number is group times 24, plus port times 8, plus bit
	genvar g;
	genvar k;
	generate
		for (g = 0; g < pio_pkg::NUM_GROUPS; g++) // [RULE_01]
		begin : gen_group
			assign in_mask[g*pio_pkg::GROUP_W +: pio_pkg::GROUP_W] = group_in_mask(dir[g]);
			// Edge, not level; only when the jumper routes it and the bit is an input
			assign ext_rise[g] = external_irq_jumper[g] // [RULE_07]
				& in_mask[g*pio_pkg::GROUP_W + pio_pkg::EXT_BIT]
				& sync2[g*pio_pkg::GROUP_W + pio_pkg::EXT_BIT]
				& ~prev[g*pio_pkg::GROUP_W + pio_pkg::EXT_BIT];
		end
		for (k = 0; k < pio_pkg::NUM_PORTS; k++)
		begin : gen_port
			// Output bits of a split port C are never watched
			assign mon_mask[k*pio_pkg::PORT_W +: pio_pkg::PORT_W] =
				{pio_pkg::PORT_W{cos_en[k]}} & in_mask[k*pio_pkg::PORT_W +: pio_pkg::PORT_W]; // [RULE_05]
		end
	endgenerate

	// Inputs read their pin, outputs read back their latch
	assign rd_lines = (in_mask & sync2) | (~in_mask & latch); // [RULE_03]
	assign set_ev.cos = |((sync2 ^ prev) & mon_mask); // [RULE_04] [RULE_15]
	assign set_ev.ext0 = ext_rise[0];
	assign set_ev.ext1 = ext_rise[1];
	// Neither jumper fitted leaves every driver off; the always-on
	// jumper overrides whatever software left in the soft bit
	assign buf_on = buffer_always_on_jumper | (buffer_soft_control_jumper & buf_soft); // [RULE_13]

	////////////////////////////////////////////////////////////////////////////
	// Data index layout; the byte address is four times the index
	//   0, 1, 2  group 0 ports A, B and C
	//   3        group 0 direction, a set bit makes lines inputs
	//   4, 5, 6  group 1 ports A, B and C
	//   7        group 1 direction
	//   8        change detection enables, one bit per port
	//   9        sticky interrupt status, a written one clears a bit
	//   10       buffer control: soft enable, effective enable
	//   11 to 15 spare: read as zero, writes ignored
	// Reads show the pin on input bits and the latch on output bits
	// Every setup is answered at once, so the bus never stalls;
	// an unmapped address still completes, flagged by pslverr
	// APB decode: index is paddr[5:2], upper bits must be zero
	assign idx = paddr[5:2];
	assign addr_ok = (paddr[pio_pkg::ADDR_W-1:6] == 2'h0); // [RULE_11]
	assign wr = psel & penable & pready & pwrite & addr_ok;

	// Zero-wait slave: answer registered in setup, presented in access
	always_comb
	begin
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~addr_ok;
		next_prdata_valid = psel & ~penable & ~pwrite & addr_ok;
		next_prdata = 32'h0;
		if (!next_prdata_valid)
		begin
			next_prdata = 32'h0;
		end
		else if (idx < pio_pkg::IDX_COS_ENABLE)
		begin
			if (idx[1:0] == pio_pkg::SUB_CTRL)
			begin
				next_prdata = {28'h0, dir[idx[2]]};
			end
			else
			begin
				next_prdata = {24'h0, rd_lines[port_base(idx) +: 8]};
			end
		end
		else if (idx == pio_pkg::IDX_COS_ENABLE)
		begin
			next_prdata = {26'h0, cos_en};
		end
		else if (idx == pio_pkg::IDX_IRQ_STATUS)
		begin
			next_prdata = {29'h0, status};
		end
		else if (idx == pio_pkg::IDX_BUFFER_CTRL)
		begin
			next_prdata = {30'h0, buf_on, buf_soft};
		end
		else
		begin
			next_prdata = 32'h0; // Spare locations read as zero
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software-visible registers
	always_comb
	begin
		next_latch = latch;
		next_dir = dir;
		next_cos_en = cos_en;
		next_buf_soft = buf_soft;
		// Status bits: 0 change detect, 1 group 0 external, 2 group 1 external.
		// A written one clears a bit, but an event in the same clock keeps it,
		// so no event is lost while software acknowledges an older one.
		// Hardware set beats a clear in the same cycle
		next_status = status | set_ev; // [RULE_04] [RULE_07]
		if (wr && idx < pio_pkg::IDX_COS_ENABLE)
		begin
			if (idx[1:0] == pio_pkg::SUB_CTRL)
			begin
				next_dir[idx[2]] = pwdata[pio_pkg::DIR_W-1:0]; // [RULE_09]
			end
			else
			begin
				next_latch[port_base(idx) +: 8] = pwdata[7:0]; // [RULE_03]
			end
		end
		else if (wr && idx == pio_pkg::IDX_COS_ENABLE)
		begin
			next_cos_en = pwdata[pio_pkg::NUM_PORTS-1:0]; // [RULE_05]
		end
		else if (wr && idx == pio_pkg::IDX_IRQ_STATUS)
		begin
			next_status = (status & ~pwdata[2:0]) | set_ev; // [RULE_06]
		end
		else if (wr && idx == pio_pkg::IDX_BUFFER_CTRL)
		begin
			next_buf_soft = pwdata[0]; // [RULE_10]
		end
	end

	// Reset leaves every port an input and every latch clear,
	// so nothing drives the pins until software asks for it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			latch <= pio_pkg::LATCH_RESET;
			dir[0] <= pio_pkg::DIR_RESET; // [RULE_12]
			dir[1] <= pio_pkg::DIR_RESET;
			cos_en <= pio_pkg::COS_EN_RESET;
			buf_soft <= pio_pkg::BUF_SOFT_RESET;
			status <= pio_pkg::IRQ_RESET;
		end
		else
		begin
			latch <= next_latch;
			dir <= next_dir;
			cos_en <= next_cos_en;
			buf_soft <= next_buf_soft;
			status <= next_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin side: drivers, synchroniser and interrupt outputs
	// Limitations for users of the pin side:
	// a level lasting less than one clock may never reach sync2;
	// turning a port to input can fire a change event if its pin differs
	// from the last sample, so enable detection after the turn;
	// the drivers follow the jumpers at the next edge, a soft bit write one edge later;
	// irq and the indicator share one source, so they rise and fall together
	always_comb
	begin
		next_line_out = next_latch;
		next_line_oe = {pio_pkg::NUM_LINES{buf_on}} & ~group_in_mask_all(next_dir); // [RULE_09] [RULE_10]
		next_irq = |next_status; // [RULE_08]
	end

	function automatic logic [pio_pkg::NUM_LINES-1:0] group_in_mask_all
	(
		input logic [pio_pkg::DIR_W-1:0] d [pio_pkg::NUM_GROUPS]
	);
		group_in_mask_all = {group_in_mask(d[1]), group_in_mask(d[0])};
	endfunction

	// Two flops then a history copy; only sync2 and prev feed logic
	// Pins rest high, so the history starts high: no false edge after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1 <= pio_pkg::PIN_RESET;
			sync2 <= pio_pkg::PIN_RESET;
			prev <= pio_pkg::PIN_RESET;
			line_out <= pio_pkg::LATCH_RESET;
			line_oe <= 48'h0; // [RULE_12]
			irq <= 1'b0;
			irq_led <= 1'b0;
		end
		else
		begin
			sync1 <= line_in;
			sync2 <= sync1; // [RULE_15]
			prev <= sync2;
			line_out <= next_line_out;
			line_oe <= next_line_oe;
			irq <= next_irq;
			irq_led <= next_irq; // [RULE_14]
		end
	end

endmodule // pio_top

/* File: test/pio_field.sv */
module pio_field
(
	input wire logic [47:0] line_out,
	input wire logic [47:0] line_oe,
	input wire logic [47:0] ext_en,
	input wire logic [47:0] ext_val,
	output logic [47:0] line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Undriven lines rest high on the pull-ups, never on a stale value
	always_comb line_in = (line_oe & line_out) | (~line_oe & ~ext_en) | (~line_oe & ext_en & ext_val);
endmodule // pio_field

/* File: test/pio_checker_properties.sv */
module pio_checker
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pio_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [pio_pkg::NUM_LINES-1:0] line_oe,
	input wire logic buffer_always_on_jumper,
	input wire logic buffer_soft_control_jumper,
	input wire logic irq,
	input wire logic irq_led
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic clr;
	// Status write; irq clears on the same edge as the status bits, yet two cycles are excused
	assign clr = psel && penable && pwrite && paddr == 8'h24;
	////////////////////////////////////////////////////////////////////////////
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_err; psel && !penable && paddr[7:6] != 2'h0 |=> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_errrdy; pslverr |-> pready; endproperty
	a_errrdy: assert property (p_errrdy) else $error("error without ready");
	property p_rd0; !pready |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside access");
	property p_led; irq_led == irq; endproperty
	a_led: assert property (p_led) else $error("indicator differs from irq");
	property p_hold; irq && !clr && !$past(clr) |=> irq; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped without clear");
	property p_off; !buffer_always_on_jumper && !buffer_soft_control_jumper |=> line_oe == '0; endproperty
	a_off: assert property (p_off) else $error("drivers on without jumper");
	property p_rst; $rose(presetn) |-> line_oe == '0 && !irq; endproperty
	a_rst: assert property (p_rst) else $error("active after reset");
endmodule // pio_checker
bind pio_top pio_checker pio_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .line_oe, .buffer_always_on_jumper,
	.buffer_soft_control_jumper, .irq, .irq_led);

/* File: test/parallel_io_change_of_state_tb_top.sv */
module parallel_io_change_of_state_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, irq_led, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [47:0] line_in, line_out, line_oe, ext_en = 48'h0, ext_val = 48'h0;
	logic [1:0] external_irq_jumper = 2'h0;
	logic buffer_always_on_jumper = 0, buffer_soft_control_jumper = 1;
	int mismatches = 0, n_compared = 0;
	always #10 pclk = ~pclk;
	pio_top pio_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .line_in, .line_out, .line_oe, .external_irq_jumper,
		.buffer_always_on_jumper, .buffer_soft_control_jumper, .irq, .irq_led);
	pio_field pio_field_i (.line_out, .line_oe, .ext_en, .ext_val, .line_in);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 16)
		begin
			mismatches++;
			final_report();
		end
	endtask
	// Longer than the three-cycle pin-to-irq path
	task automatic settle;
		repeat (6) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk({line_oe[46:0], irq}, 48'h0, "idle after reset");
		apb(0, 8'h1c, 0);
		chk({16'h0, rd}, 48'hf, "direction reset");
		apb(1, 8'h28, 32'h1);
		apb(1, 8'h0c, 32'h4);
		apb(1, 8'h00, 32'ha5);
		apb(1, 8'h08, 32'h3c);
		settle;
		chk(line_oe, 48'hf0ffff, "drivers follow direction");
		chk(line_out & line_oe, 48'h3000a5, "latched outputs");
		apb(0, 8'h08, 0);
		chk({16'h0, rd}, 48'h3f, "split port read");
		$display("test ports done");
		apb(1, 8'h28, 0);
		settle;
		chk(line_oe, 48'h0, "soft disable");
		buffer_always_on_jumper <= 1;
		settle;
		chk(line_oe, 48'hf0ffff, "always on");
		buffer_always_on_jumper <= 0;
		buffer_soft_control_jumper <= 0;
		settle;
		$display("test buffers done");
		apb(1, 8'h20, 32'h8);
		ext_en[32] <= 1;
		ext_en[19] <= 1;
		settle;
		ext_val[19] <= 1;
		settle;
		chk({47'h0, irq}, 48'h0, "disabled port or jumper");
		ext_en[24] <= 1;
		settle;
		chk({46'h0, irq, irq_led}, 48'h3, "change irq");
		apb(0, 8'h14, 0);
		chk({16'h0, rd}, 48'hfe, "group 1 port B read");
		apb(0, 8'h24, 0);
		settle;
		chk({15'h0, irq, rd}, 48'h1_0000_0001, "status held");
		apb(1, 8'h24, 32'h1);
		settle;
		chk({47'h0, irq}, 48'h0, "cleared");
		$display("test change done");
		external_irq_jumper <= 2'h2;
		ext_en[43] <= 1;
		settle;
		chk({47'h0, irq}, 48'h0, "falling edge");
		ext_val[43] <= 1;
		settle;
		apb(0, 8'h24, 0);
		chk({15'h0, irq, rd}, 48'h1_0000_0004, "external irq");
		apb(1, 8'h24, 32'h4);
		apb(0, 8'h40, 0);
		chk({15'h0, er, rd}, 48'h1_0000_0000, "unmapped");
		apb(0, 8'h2c, 0);
		chk({15'h0, er, rd}, 48'h0, "reserved index");
		settle;
		chk({47'h0, irq_led}, 48'h0, "indicator off");
		$display("test external done");
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		settle;
		chk({47'h0, irq}, 48'h0, "no edge after reset");
		apb(0, 8'h0c, 0);
		chk({16'h0, rd}, 48'hf, "direction after reset");
		$display("test reset done");
		final_report();
	end
endmodule // parallel_io_change_of_state_tb_top
